// [stmh_defs.vh]
// Constants for the target-mode message handler: message codes, actions, sequences.
// Assumes an 8-bit message byte interface from a bus phase engine.
`ifndef STMH_DEFS_VH
`define STMH_DEFS_VH
`define STMH_MSG_CMD_CPLT 8'h00
`define STMH_MSG_EXT 8'h01
`define STMH_MSG_SAVE_PTR 8'h02
`define STMH_MSG_RESTORE_PTR 8'h03
`define STMH_MSG_DISCONNECT 8'h04
`define STMH_MSG_INIT_ERR 8'h05
`define STMH_MSG_ABORT 8'h06
`define STMH_MSG_REJECT 8'h07
`define STMH_MSG_NOP 8'h08
`define STMH_MSG_PAR_ERR 8'h09
`define STMH_MSG_LINK_CPLT 8'h0a
`define STMH_MSG_LINK_CPLT_F 8'h0b
`define STMH_MSG_DEV_RESET 8'h0c
`define STMH_MSG_ABORT_TAG 8'h0d
`define STMH_MSG_CLR_QUEUE 8'h0e
`define STMH_MSG_SIMPLE_TAG 8'h20
`define STMH_MSG_HEAD_TAG 8'h21
`define STMH_MSG_ORDER_TAG 8'h22
`define STMH_MSG_IDENT_BIT 7
`define STMH_IDENT_DISC_BIT 6
`define STMH_EXT_SYNC 8'h01
`define STMH_EXT_WIDE 8'h03
`define STMH_LEN_TAG 3'h2
`define STMH_LEN_SYNC 3'h5
`define STMH_LEN_WIDE 3'h4
`define STMH_STAT_BUSY 8'h08
`define STMH_STAT_CHECK 8'h02
// Host sequence codes
`define STMH_SEQ_STAT_CPLT 3'h0
`define STMH_SEQ_SAVE_DISC 3'h1
`define STMH_SEQ_STAT_LINK 3'h2
`define STMH_SEQ_STAT_LINKF 3'h3
`define STMH_SEQ_REJECT 3'h4
`define STMH_SEQ_RESTORE 3'h5
// Bus actions
`define STMH_ACT_NONE 3'h0
`define STMH_ACT_BUS_FREE 3'h1
`define STMH_ACT_REQ_CMD 3'h2
`define STMH_ACT_RETRY 3'h3
`define STMH_ACT_HOLD 3'h4
`define STMH_ACT_RESUME 3'h5
`define STMH_ACT_RESEND 3'h6
// Last phase codes
`define STMH_PH_DATA 2'h0
`define STMH_PH_STATUS 2'h1
`define STMH_PH_CMD 2'h2
`define STMH_PH_OTHER 2'h3
`endif

// [stmh_init_model.sv]
// Remote initiator model: sends message bytes, takes outgoing bytes.
// Assumes the handler holds tx_byte until tx_ack.
`timescale 1ns/1ns
module stmh_init_model (
  input logic clk_sys,
  input logic arst_n,
  input logic [1:0] dly,
  input logic tx_valid,
  input logic [7:0] tx_byte,
  output logic tx_ack,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_end
);
  logic [7:0] got[$];
  logic [1:0] wait_reg;
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h5a;
    rx_end = 1'b0;
  end
  // Slow acks make the handler hold each byte
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_ack <= 1'b0;
      wait_reg <= 2'h0;
    end else if (tx_ack) begin
      tx_ack <= 1'b0;
      got.push_back(tx_byte);
    end else if (tx_valid && wait_reg >= dly) begin
      tx_ack <= 1'b1;
      wait_reg <= 2'h0;
    end else if (tx_valid) begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
  // First byte first; the line shows the inverse once released
  task automatic send(input [63:0] d, input integer n);
    integer i;
    for (i = 0; i < n; i++) begin
      @(posedge clk_sys);
      rx_valid <= 1'b1;
      rx_byte <= d[8*i +: 8];
    end
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    rx_end <= 1'b1;
    @(posedge clk_sys);
    rx_end <= 1'b0;
  endtask
endmodule // stmh_init_model

// [stmh_msg_handler.v]
// Target-mode message handler: classifies initiator message bytes, emits sequences.
// Assumes a phase engine delivering received bytes with rx_valid and end of ATN with rx_end.
// Summary of operation
// (RQ1) Abort: clear queue; hold bus and forward if identified, else bus free
// (RQ2) Abort Tag: clear current, hold, forward
// (RQ3) Bus Device Reset: hard reset, hold, forward
// (RQ4) Clear Queue: abort all, hold, forward
// (RQ5) Identify only once per selection, else reject
// (RQ6) Initiator error: restore and retry, else forward
// (RQ7) Parity error while sending: resend whole message
// (RQ8) Parity error otherwise: bus free, forward
// (RQ9) Reject while not sending: reject; else forward
// (RQ10) No Operation: discard and resume
// (RQ11) Queue tags: pass two bytes, reject if short
// (RQ12) Sync request: clamp period/offset, echo or reject
// (RQ13) Wide request: reply smaller width, reject short
// (RQ14) Unknown messages get Message Reject
// (RQ15) Status plus Command Complete, then bus free
// (RQ16) Save pointer plus Disconnect, then bus free
// (RQ17) Status plus linked complete, then request command
// (RQ18) Host requests only supported sequences
// (RQ19) Tagged reselection sends tag after Identify
// (RQ20) Target disabled: Busy then Command Complete
// (RQ21) After command, disconnect if Identify allows
// (RQ22) Reselection Identify carries host's unit number
// (RQ23) Retry limit: check condition, complete; a parity error while sending gets fatal_error and bus free instead
`timescale 1ns/1ns
`include "stmh_defs.vh"
module stmh_msg_handler (
  clk_sys,
  arst_n,
  rx_valid,
  rx_byte,
  rx_end,
  selected,
  cdb_done,
  last_phase,
  status_sent,
  target_enable,
  sync_enable,
  cfg_period,
  cfg_offset,
  cfg_wide,
  cfg_retry_limit,
  host_seq_valid,
  host_seq,
  host_status,
  host_lun,
  host_tagged,
  host_tag,
  host_tag_type,
  host_seq_ready,
  tx_ack,
  tx_valid,
  tx_byte,
  tx_last,
  msg_to_host,
  msg_byte,
  queue_tag_valid,
  queue_tag_type,
  queue_tag,
  clear_current,
  clear_lun_queue,
  clear_all,
  hard_reset,
  bus_action,
  hold_bus,
  disconnect_ok,
  fatal_error,
  retry_exhausted
);
  input clk_sys;
  input arst_n;
  input rx_valid;
  input [7:0] rx_byte;
  input rx_end;
  input selected;
  input cdb_done;
  input [1:0] last_phase;
  input status_sent;
  input target_enable;
  input sync_enable;
  input [7:0] cfg_period;
  input [7:0] cfg_offset;
  input [1:0] cfg_wide;
  input [3:0] cfg_retry_limit;
  input host_seq_valid;
  input [2:0] host_seq;
  input [7:0] host_status;
  input [2:0] host_lun;
  input host_tagged;
  input [7:0] host_tag;
  input [7:0] host_tag_type;
  output host_seq_ready;
  input tx_ack;
  output tx_valid;
  output [7:0] tx_byte;
  output tx_last;
  output msg_to_host;
  output [7:0] msg_byte;
  output queue_tag_valid;
  output [7:0] queue_tag_type;
  output [7:0] queue_tag;
  output clear_current;
  output clear_lun_queue;
  output clear_all;
  output hard_reset;
  output [2:0] bus_action;
  output hold_bus;
  output disconnect_ok;
  output fatal_error;
  output retry_exhausted;
  localparam ST_IDLE = 4'b0001;
  localparam ST_RECV = 4'b0010;
  localparam ST_SEND = 4'b0100;
  localparam ST_HOLD = 4'b1000;
  reg [3:0] state_reg;
  reg [7:0] buf_reg [0:4];
  reg [2:0] cnt_reg;
  reg ident_seen_reg;
  reg disc_ok_reg;
  reg [3:0] retry_reg;
  reg [63:0] last_msg_reg;
  reg [3:0] last_len_reg;
  reg [2:0] after_reg;
  reg msg_to_host_reg;
  reg [7:0] msg_byte_reg;
  reg qt_valid_reg;
  reg [7:0] qt_type_reg;
  reg [7:0] qt_reg;
  reg clr_cur_reg, clr_lun_reg, clr_all_reg, hard_reset_reg;
  reg [2:0] bus_action_reg;
  reg fatal_reg;
  reg exhausted_reg;
  reg sel_d_reg;
  reg cdb_d_reg;
  reg ld;
  reg [3:0] ld_len;
  reg [63:0] ld_data;
  reg [2:0] ld_after;
  wire sent_done;
  wire sending = (state_reg == ST_SEND);
  assign host_seq_ready = (state_reg == ST_IDLE) || (state_reg == ST_HOLD);
  assign msg_to_host = msg_to_host_reg;
  assign msg_byte = msg_byte_reg;
  assign queue_tag_valid = qt_valid_reg;
  assign queue_tag_type = qt_type_reg;
  assign queue_tag = qt_reg;
  assign clear_current = clr_cur_reg;
  assign clear_lun_queue = clr_lun_reg;
  assign clear_all = clr_all_reg;
  assign hard_reset = hard_reset_reg;
  assign bus_action = bus_action_reg;
  assign hold_bus = (state_reg == ST_HOLD);
  assign disconnect_ok = disc_ok_reg;
  assign fatal_error = fatal_reg;
  assign retry_exhausted = exhausted_reg;
  // Pack two bytes, first byte in the low lane
  function [63:0] pack2;
    input [7:0] b0;
    input [7:0] b1;
    begin
      pack2 = {48'h0, b1, b0};
    end
  endfunction
  function [7:0] min8;
    input [7:0] a;
    input [7:0] b;
    begin
      min8 = (a < b) ? a : b;
    end
  endfunction
  // Expected length of a multi-byte message from its first byte and code
  function [2:0] need_len;
    input [7:0] b0;
    input [7:0] code;
    begin
      if (b0 == `STMH_MSG_EXT)
        need_len = (code == `STMH_EXT_SYNC) ? `STMH_LEN_SYNC :
                   (code == `STMH_EXT_WIDE) ? `STMH_LEN_WIDE : 3'h2;
      else if (b0 == `STMH_MSG_SIMPLE_TAG || b0 == `STMH_MSG_HEAD_TAG || b0 == `STMH_MSG_ORDER_TAG)
        need_len = `STMH_LEN_TAG;
      else
        need_len = 3'h1;
    end
  endfunction
  stmh_tx_buf u_tx (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .load(ld),
    .load_len(ld_len),
    .load_data(ld_data),
    .tx_ack(tx_ack),
    .tx_valid(tx_valid),
    .tx_byte(tx_byte),
    .tx_last(tx_last),
    .done(sent_done)
  );
  wire [7:0] b0 = buf_reg[0];
  wire [2:0] need = need_len(buf_reg[0], buf_reg[2]);
  wire msg_complete = (cnt_reg != 3'h0) && (cnt_reg >= need) && (cnt_reg > 3'h2 || b0 != `STMH_MSG_EXT);
  wire msg_short = rx_end && (cnt_reg != 3'h0) && !msg_complete;
  wire retry_left = (retry_reg < cfg_retry_limit);
  wire [63:0] reject_data = {56'h0, `STMH_MSG_REJECT};
  wire [63:0] busy_data = pack2(`STMH_STAT_BUSY, `STMH_MSG_CMD_CPLT);
  wire [7:0] ident_out = {1'b1, 4'h0, host_lun};
  // Offending retry falls back to check condition plus complete
  wire [63:0] check_data = status_sent ?
    {40'h0, `STMH_MSG_CMD_CPLT, `STMH_STAT_CHECK, `STMH_MSG_RESTORE_PTR} :
    pack2(`STMH_STAT_CHECK, `STMH_MSG_CMD_CPLT);
  wire [7:0] sync_per = (buf_reg[3] < cfg_period) ? cfg_period : buf_reg[3];
  wire [7:0] sync_off = min8(buf_reg[4], cfg_offset);
  wire [7:0] wide_w = min8(buf_reg[3], {6'h0, cfg_wide});
  integer i;
  always @* begin
    ld = 1'b0;
    ld_len = 4'h0;
    ld_data = 64'h0;
    ld_after = `STMH_ACT_NONE;
    if (state_reg == ST_IDLE && selected && !sel_d_reg && !target_enable) begin
      ld = 1'b1; // RQ20
      ld_len = 4'h2;
      ld_data = busy_data;
      ld_after = `STMH_ACT_BUS_FREE;
    end else if (state_reg == ST_IDLE && cdb_done && !cdb_d_reg && disc_ok_reg) begin
      ld = 1'b1; // RQ21
      ld_len = 4'h1;
      ld_data = {56'h0, `STMH_MSG_DISCONNECT};
      ld_after = `STMH_ACT_BUS_FREE;
    end else if (sending && rx_valid && rx_byte == `STMH_MSG_PAR_ERR && retry_left) begin
      ld = 1'b1; // RQ7
      ld_len = last_len_reg;
      ld_data = last_msg_reg;
      ld_after = after_reg;
    end else if (host_seq_ready && host_seq_valid) begin
      ld = 1'b1;
      case (host_seq)
        `STMH_SEQ_STAT_CPLT: begin
          ld_len = 4'h2; // RQ15
          ld_data = pack2(host_status, `STMH_MSG_CMD_CPLT);
          ld_after = `STMH_ACT_BUS_FREE;
        end
        `STMH_SEQ_SAVE_DISC: begin
          ld_len = 4'h2; // RQ16
          ld_data = pack2(`STMH_MSG_SAVE_PTR, `STMH_MSG_DISCONNECT);
          ld_after = `STMH_ACT_BUS_FREE;
        end
        `STMH_SEQ_STAT_LINK, `STMH_SEQ_STAT_LINKF: begin
          ld_len = 4'h2; // RQ17
          ld_data = pack2(host_status, (host_seq == `STMH_SEQ_STAT_LINK) ?
                          `STMH_MSG_LINK_CPLT : `STMH_MSG_LINK_CPLT_F);
          ld_after = `STMH_ACT_REQ_CMD;
        end
        `STMH_SEQ_REJECT: begin
          ld_len = 4'h1; // RQ18
          ld_data = reject_data;
          ld_after = `STMH_ACT_RESUME;
        end
        `STMH_SEQ_RESTORE: begin
          ld_len = 4'h1;
          ld_data = {56'h0, `STMH_MSG_RESTORE_PTR};
          ld_after = `STMH_ACT_RESUME;
        end
        default: begin
          // Reselection: Identify, then the queue tag if the process was tagged
          ld_len = host_tagged ? 4'h3 : 4'h1; // RQ22
          ld_data = {40'h0, host_tag, host_tag_type, ident_out}; // RQ19
          ld_after = `STMH_ACT_RESUME;
        end
      endcase
    end else if (state_reg == ST_RECV && msg_short) begin
      ld = 1'b1; // RQ11 RQ12 RQ13
      ld_len = 4'h1;
      ld_data = reject_data;
      ld_after = `STMH_ACT_RESUME;
    end else if (state_reg == ST_RECV && msg_complete) begin
      ld_len = 4'h1;
      ld_data = reject_data;
      ld_after = `STMH_ACT_RESUME;
      if (b0[`STMH_MSG_IDENT_BIT]) begin
        ld = ident_seen_reg; // RQ5
      end else if (b0 == `STMH_MSG_INIT_ERR) begin
        if (last_phase == `STMH_PH_DATA || last_phase == `STMH_PH_STATUS) begin
          ld = 1'b1; // RQ6
          ld_data = retry_left ? {56'h0, `STMH_MSG_RESTORE_PTR} : check_data;
          ld_len = retry_left ? 4'h1 : (status_sent ? 4'h3 : 4'h2); // RQ23
          ld_after = retry_left ? `STMH_ACT_RETRY : `STMH_ACT_BUS_FREE;
        end
      end else if (b0 == `STMH_MSG_REJECT) begin
        ld = 1'b1; // RQ9
      end else if (b0 == `STMH_MSG_EXT && buf_reg[2] == `STMH_EXT_SYNC) begin
        ld = 1'b1; // RQ12
        if (sync_enable) begin
          ld_len = 4'h5;
          ld_data = {24'h0, sync_off, sync_per, buf_reg[2], buf_reg[1], b0};
        end
      end else if (b0 == `STMH_MSG_EXT && buf_reg[2] == `STMH_EXT_WIDE) begin
        ld = 1'b1; // RQ13
        ld_len = 4'h4;
        ld_data = {32'h0, wide_w, buf_reg[2], buf_reg[1], b0};
      end else if (b0 == `STMH_MSG_ABORT || b0 == `STMH_MSG_ABORT_TAG || b0 == `STMH_MSG_DEV_RESET ||
                   b0 == `STMH_MSG_CLR_QUEUE || b0 == `STMH_MSG_NOP || b0 == `STMH_MSG_PAR_ERR ||
                   b0 == `STMH_MSG_SIMPLE_TAG || b0 == `STMH_MSG_HEAD_TAG || b0 == `STMH_MSG_ORDER_TAG) begin
        ld = 1'b0;
      end else begin
        ld = 1'b1; // RQ14
      end
    end
  end
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      for (i = 0; i < 5; i = i + 1)
        buf_reg[i] <= 8'h00;
      cnt_reg <= 3'h0;
      ident_seen_reg <= 1'b0;
      disc_ok_reg <= 1'b0;
      retry_reg <= 4'h0;
      last_msg_reg <= 64'h0;
      last_len_reg <= 4'h0;
      after_reg <= `STMH_ACT_NONE;
      msg_to_host_reg <= 1'b0;
      msg_byte_reg <= 8'h00;
      qt_valid_reg <= 1'b0;
      qt_type_reg <= 8'h00;
      qt_reg <= 8'h00;
      clr_cur_reg <= 1'b0;
      clr_lun_reg <= 1'b0;
      clr_all_reg <= 1'b0;
      hard_reset_reg <= 1'b0;
      bus_action_reg <= `STMH_ACT_NONE;
      fatal_reg <= 1'b0;
      exhausted_reg <= 1'b0;
      sel_d_reg <= 1'b0;
      cdb_d_reg <= 1'b0;
    end else begin
      msg_to_host_reg <= 1'b0;
      qt_valid_reg <= 1'b0;
      clr_cur_reg <= 1'b0;
      clr_lun_reg <= 1'b0;
      clr_all_reg <= 1'b0;
      hard_reset_reg <= 1'b0;
      bus_action_reg <= `STMH_ACT_NONE;
      fatal_reg <= 1'b0;
      exhausted_reg <= 1'b0;
      sel_d_reg <= selected;
      cdb_d_reg <= cdb_done;
      if (selected && !sel_d_reg) begin
        ident_seen_reg <= 1'b0;
        retry_reg <= 4'h0;
      end
      if (ld) begin
        last_msg_reg <= ld_data;
        last_len_reg <= ld_len;
        after_reg <= ld_after;
        cnt_reg <= 3'h0;
        state_reg <= ST_SEND;
        if (ld_after == `STMH_ACT_RETRY || sending)
          retry_reg <= retry_reg + 4'h1;
        if (ld_data == check_data && ld_after == `STMH_ACT_BUS_FREE && state_reg == ST_RECV)
          exhausted_reg <= 1'b1; // RQ23
      end else if (state_reg == ST_SEND) begin
        if (rx_valid && rx_byte == `STMH_MSG_PAR_ERR) begin
          fatal_reg <= 1'b1; // RQ23
          bus_action_reg <= `STMH_ACT_BUS_FREE;
          state_reg <= ST_IDLE;
        end else if (rx_valid && rx_byte == `STMH_MSG_REJECT) begin
          msg_to_host_reg <= 1'b1; // RQ9
          msg_byte_reg <= rx_byte;
          state_reg <= ST_HOLD;
        end else if (sent_done) begin
          bus_action_reg <= after_reg;
          state_reg <= ST_IDLE;
        end
      end else if (state_reg == ST_HOLD) begin
        if (host_seq_valid)
          state_reg <= ST_IDLE;
      end else if (state_reg == ST_RECV) begin
        if (rx_valid && cnt_reg != 3'h5) begin
          buf_reg[cnt_reg] <= rx_byte;
          cnt_reg <= cnt_reg + 3'h1;
        end
        if (msg_complete) begin
          cnt_reg <= 3'h0;
          state_reg <= ST_IDLE;
          if (b0[`STMH_MSG_IDENT_BIT] && !ident_seen_reg) begin
            ident_seen_reg <= 1'b1;
            disc_ok_reg <= b0[`STMH_IDENT_DISC_BIT];
          end else if (b0 == `STMH_MSG_ABORT) begin
            clr_cur_reg <= 1'b1; // RQ1
            clr_lun_reg <= 1'b1;
            if (ident_seen_reg) begin
              msg_to_host_reg <= 1'b1;
              msg_byte_reg <= b0;
              state_reg <= ST_HOLD;
            end else begin
              bus_action_reg <= `STMH_ACT_BUS_FREE;
            end
          end else if (b0 == `STMH_MSG_ABORT_TAG || b0 == `STMH_MSG_DEV_RESET || b0 == `STMH_MSG_CLR_QUEUE) begin
            clr_cur_reg <= 1'b1; // RQ2
            hard_reset_reg <= (b0 == `STMH_MSG_DEV_RESET); // RQ3
            clr_all_reg <= (b0 != `STMH_MSG_ABORT_TAG); // RQ4
            msg_to_host_reg <= 1'b1;
            msg_byte_reg <= b0;
            state_reg <= ST_HOLD;
          end else if (b0 == `STMH_MSG_PAR_ERR) begin
            fatal_reg <= 1'b1; // RQ8
            msg_to_host_reg <= 1'b1;
            msg_byte_reg <= b0;
            bus_action_reg <= `STMH_ACT_BUS_FREE;
          end else if (b0 == `STMH_MSG_INIT_ERR) begin
            msg_to_host_reg <= 1'b1; // RQ6
            msg_byte_reg <= b0;
            state_reg <= ST_HOLD;
          end else if (b0 == `STMH_MSG_NOP) begin
            bus_action_reg <= `STMH_ACT_RESUME; // RQ10
          end else if (b0 == `STMH_MSG_SIMPLE_TAG || b0 == `STMH_MSG_HEAD_TAG || b0 == `STMH_MSG_ORDER_TAG) begin
            qt_valid_reg <= 1'b1; // RQ11
            qt_type_reg <= b0;
            qt_reg <= buf_reg[1];
          end
        end else if (rx_end) begin
          cnt_reg <= 3'h0;
          state_reg <= ST_IDLE;
        end
      end else if (rx_valid) begin
        buf_reg[0] <= rx_byte;
        cnt_reg <= 3'h1;
        state_reg <= ST_RECV;
      end
    end
  end
endmodule // stmh_msg_handler

// [stmh_msg_handler_properties.sv]
// Port checker for the target message handler.
// Assumes binding to stmh_msg_handler; one clock, reset async low.
`timescale 1ns/1ns
`include "stmh_defs.vh"
module stmh_chk (
  input logic clk_sys,
  input logic arst_n,
  input logic host_seq_valid,
  input logic [2:0] host_seq,
  input logic [7:0] host_status,
  input logic host_seq_ready,
  input logic tx_ack,
  input logic tx_valid,
  input logic [7:0] tx_byte,
  input logic tx_last,
  input logic msg_to_host,
  input logic [7:0] msg_byte,
  input logic queue_tag_valid,
  input logic [7:0] queue_tag_type,
  input logic hard_reset,
  input logic [2:0] bus_action,
  input logic hold_bus
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  logic [7:0] stat_reg;
  wire acc = host_seq_valid && host_seq_ready;
  // Latched at acceptance, the host may move it afterwards
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stat_reg <= 8'h00;
    end else if (acc) begin
      stat_reg <= host_status;
    end
  end
  a_tx_byte_held: assert property (tx_valid && !tx_ack |=> tx_valid && $stable(tx_byte))
    else $error("byte moved before ack");
  a_seq_refused: assert property (tx_valid |-> !host_seq_ready)
    else $error("host taken while sending");
  a_last_in_byte: assert property (tx_last |-> tx_valid)
    else $error("last flag without byte");
  a_action_pulse: assert property (bus_action != `STMH_ACT_NONE |=> bus_action == `STMH_ACT_NONE)
    else $error("bus action too long");
  a_status_first: assert property (acc && host_seq inside {`STMH_SEQ_STAT_CPLT,
    `STMH_SEQ_STAT_LINK, `STMH_SEQ_STAT_LINKF}
    |=> ##[0:3] (tx_valid && tx_byte == stat_reg)) else $error("status byte not first");
  a_cplt_free: assert property (acc && host_seq == `STMH_SEQ_STAT_CPLT
    |-> ##[2:60] bus_action == `STMH_ACT_BUS_FREE) else $error("no bus free after complete");
  a_link_next: assert property (acc && host_seq inside {`STMH_SEQ_STAT_LINK,
    `STMH_SEQ_STAT_LINKF} |-> ##[2:60] bus_action == `STMH_ACT_REQ_CMD)
    else $error("no command request after linked");
  a_save_disc: assert property (acc && host_seq == `STMH_SEQ_SAVE_DISC
    |=> ##[0:3] (tx_valid && tx_byte == `STMH_MSG_SAVE_PTR)) else $error("save pointer not sent");
  a_forward_hold: assert property (msg_to_host && msg_byte inside {`STMH_MSG_ABORT,
    `STMH_MSG_ABORT_TAG, `STMH_MSG_CLR_QUEUE} |-> ##[0:2] hold_bus)
    else $error("bus not held while forwarding");
  a_reset_hold: assert property (hard_reset |-> ##[0:4] hold_bus)
    else $error("bus not held on device reset");
  a_tag_type: assert property (queue_tag_valid |-> queue_tag_type inside {8'h20, 8'h21, 8'h22})
    else $error("bad queue tag type");
endmodule // stmh_chk
bind stmh_msg_handler stmh_chk i_chk (.clk_sys, .arst_n, .host_seq_valid, .host_seq, .host_status,
  .host_seq_ready, .tx_ack, .tx_valid, .tx_byte, .tx_last, .msg_to_host, .msg_byte, .queue_tag_valid,
  .queue_tag_type, .hard_reset, .bus_action, .hold_bus);

// [stmh_tx_buf.v]
// Outgoing byte buffer of up to eight bytes, loaded whole and drained in order.
// Assumes the phase engine accepts one byte per tx_ack.
`timescale 1ns/1ns
module stmh_tx_buf (
  clk_sys,
  arst_n,
  load,
  load_len,
  load_data,
  tx_ack,
  tx_valid,
  tx_byte,
  tx_last,
  done
);
  input clk_sys;
  input arst_n;
  input load;
  input [3:0] load_len;
  input [63:0] load_data;
  input tx_ack;
  output tx_valid;
  output [7:0] tx_byte;
  output tx_last;
  output done;
  reg [63:0] data_reg;
  reg [3:0] left_reg;
  reg done_reg;
  assign tx_valid = (left_reg != 4'h0);
  assign tx_byte = data_reg[7:0];
  assign tx_last = (left_reg == 4'h1);
  assign done = done_reg;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      data_reg <= 64'h0;
      left_reg <= 4'h0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (load) begin
        data_reg <= load_data;
        left_reg <= load_len;
      end else if (tx_ack && tx_valid) begin
        // Shift rather than index so the head byte is always a plain flop
        data_reg <= {8'h00, data_reg[63:8]};
        left_reg <= left_reg - 4'h1;
        done_reg <= (left_reg == 4'h1);
      end
    end
  end
endmodule // stmh_tx_buf

// [tb.sv]
// Self-checking bench for the message handler.
// Assumes stmh_defs.vh and the bound checker.
`timescale 1ns/1ns
`include "stmh_defs.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb;
  logic clk_sys = 0, arst_n = 0, selected = 0, cdb_done = 0, status_sent = 0, target_enable = 1;
  logic sync_enable = 1, host_seq_valid = 0, host_tagged = 0, tx_ack, rx_valid, rx_end, host_seq_ready;
  logic tx_valid, tx_last, msg_to_host, queue_tag_valid, clear_current, clear_lun_queue, clear_all;
  logic hard_reset, hold_bus, disconnect_ok, fatal_error, retry_exhausted;
  logic [1:0] last_phase = 2'h3, cfg_wide = 2'h1, dly = 2'h0;
  logic [2:0] host_seq = 0, host_lun = 0, bus_action, act;
  logic [3:0] cfg_retry_limit = 4'h3;
  logic [4:0] fl;
  logic [7:0] cfg_period = 8'h19, cfg_offset = 8'h08, host_status = 0, host_tag = 0, host_tag_type = 0;
  logic [7:0] rx_byte, tx_byte, msg_byte, queue_tag_type, queue_tag, fwd, tg, p, o, w;
  logic [15:0] qt;
  logic [63:0] e;
  logic [31:0] seed = 32'hd;
  integer err_total = 0, total_checks = 0, cyc = 0, k;
  logic [7:0] unk [4] = '{8'h0f, 8'h1a, 8'h30, 8'h7f};
  logic [7:0] ab [4] = '{8'h06, 8'h0d, 8'h0c, 8'h0e};
  logic [7:0] hb [6] = '{8'h00, 8'h04, 8'h0a, 8'h0b, 8'h07, 8'h03};
  integer abi [4] = '{1, 0, 3, 2};
  stmh_msg_handler i_dut (.clk_sys, .arst_n, .rx_valid, .rx_byte, .rx_end, .selected, .cdb_done, .last_phase,
    .status_sent, .target_enable, .sync_enable, .cfg_period, .cfg_offset, .cfg_wide, .cfg_retry_limit,
    .host_seq_valid, .host_seq, .host_status, .host_lun, .host_tagged, .host_tag, .host_tag_type,
    .host_seq_ready, .tx_ack, .tx_valid, .tx_byte, .tx_last, .msg_to_host, .msg_byte, .queue_tag_valid,
    .queue_tag_type, .queue_tag, .clear_current, .clear_lun_queue, .clear_all, .hard_reset, .bus_action,
    .hold_bus, .disconnect_ok, .fatal_error, .retry_exhausted);
  stmh_init_model i_init (.clk_sys, .arst_n, .dly, .tx_valid, .tx_byte, .tx_ack, .rx_valid, .rx_byte, .rx_end);
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (msg_to_host) fwd <= msg_byte;
    if (bus_action != 3'h0) act <= bus_action;
    if (queue_tag_valid) qt <= {queue_tag_type, queue_tag};
    fl <= fl | {fatal_error, hard_reset, clear_all, clear_lun_queue, clear_current};
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic clr();
    @(negedge clk_sys);
    fl = 0;
    fwd = 0;
    act = 0;
    qt = 0;
    i_init.got.delete();
  endtask
  task automatic msg(input [63:0] d, input integer n);
    clr();
    @(posedge clk_sys);
    dly <= 2'(xs());
    i_init.send(d, n);
  endtask
  // A trailing wait makes any extra byte show as a wrong count
  task automatic exp_tx(input [63:0] x, input integer n);
    integer i = 0;
    while (i_init.got.size() < n && i < 300) begin
      @(posedge clk_sys);
      i++;
    end
    repeat (30) @(posedge clk_sys);
    `CHK("tx count", n, i_init.got.size())
    for (i = 0; i < n; i++) `CHK("tx byte", x[8*i +: 8], i_init.got[i])
  endtask
  task automatic rst();
    @(posedge clk_sys);
    arst_n <= 1'b0;
    selected <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
  endtask
  task automatic sel(input logic disc);
    repeat (4) @(posedge clk_sys);
    selected <= 1'b1;
    msg({56'h0, 1'b1, disc, 6'h0}, 1);
    repeat (10) @(posedge clk_sys);
  endtask
  // Only supported sequence codes are offered
  task automatic host(input [2:0] s);
    integer i = 0;
    clr();
    @(posedge clk_sys);
    host_seq_valid <= 1'b1;
    host_seq <= s;
    host_status <= 8'(xs());
    do @(negedge clk_sys); while (host_seq_ready !== 1'b1 && i++ < 100);
    @(posedge clk_sys);
    host_seq_valid <= 1'b0;
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    sel(1'b0);
    msg(64'hc0, 1);
    exp_tx(64'h07, 1);
    for (k = 0; k < 4; k++) begin
      msg({56'h0, unk[k]}, 1);
      exp_tx(64'h07, 1);
    end
    msg(64'h08, 1);
    exp_tx(64'h0, 0);
    msg(64'h07, 1);
    exp_tx(64'h07, 1);
    for (k = 0; k < 3; k++) begin
      tg = 8'(xs());
      msg({48'h0, tg, 8'h20 + 8'(k)}, 2);
      exp_tx(64'h0, 0);
      `CHK("queue tag", {8'h20 + 8'(k), tg}, qt)
    end
    msg(64'h21, 1);
    exp_tx(64'h07, 1);
    p = 8'(xs());
    o = 8'(xs() % 16);
    msg({24'h0, o, p, 24'h010301}, 5);
    exp_tx({24'h0, (o < cfg_offset) ? o : cfg_offset, (p > cfg_period) ? p : cfg_period, 24'h010301}, 5);
    msg({32'h0, p, 24'h010301}, 4);
    exp_tx(64'h07, 1);
    sync_enable <= 1'b0;
    msg({24'h0, o, p, 24'h010301}, 5);
    exp_tx(64'h07, 1);
    w = 8'(xs() % 3);
    msg({32'h0, w, 24'h030201}, 4);
    exp_tx({32'h0, (w < cfg_wide) ? w : {6'h0, cfg_wide}, 24'h030201}, 4);
    msg(64'h030201, 3);
    exp_tx(64'h07, 1);
    last_phase <= `STMH_PH_DATA;
    msg(64'h05, 1);
    exp_tx(64'h03, 1);
    `CHK("action", `STMH_ACT_RETRY, act)
    msg(64'h09, 1);
    exp_tx(64'h0, 0);
    `CHK("forwarded", 8'h09, fwd)
    `CHK("action", `STMH_ACT_BUS_FREE, act)
    `CHK("fatal", 1'b1, fl[4])
    last_phase <= `STMH_PH_CMD;
    msg(64'h05, 1);
    exp_tx(64'h0, 0);
    `CHK("forwarded", 8'h05, fwd)
    for (k = 0; k < 4; k++) begin
      rst();
      sel(1'b0);
      msg({56'h0, ab[k]}, 1);
      exp_tx(64'h0, 0);
      `CHK("forwarded", ab[k], fwd)
      `CHK("clear", 1'b1, fl[abi[k]])
      `CHK("hold", 1'b1, hold_bus)
    end
    for (k = 0; k < 6; k++) begin
      rst();
      sel(1'b0);
      host(3'(k));
      e = (k == 1) ? 64'h0402 : (k > 3) ? {56'h0, hb[k]} : {48'h0, hb[k], host_status};
      exp_tx(e, (k > 3) ? 1 : 2);
      if (k < 4) `CHK("action", (k < 2) ? `STMH_ACT_BUS_FREE : `STMH_ACT_REQ_CMD, act)
    end
    rst();
    sel(1'b1);
    clr();
    @(posedge clk_sys);
    cdb_done <= 1'b1;
    @(posedge clk_sys);
    cdb_done <= 1'b0;
    exp_tx(64'h04, 1);
    `CHK("action", `STMH_ACT_BUS_FREE, act)
    rst();
    clr();
    @(posedge clk_sys);
    target_enable <= 1'b0;
    selected <= 1'b1;
    exp_tx(64'h0008, 2);
    rst();
    target_enable <= 1'b1;
    host_lun <= 3'(xs());
    host_tagged <= 1'b1;
    host_tag <= 8'(xs());
    host_tag_type <= `STMH_MSG_SIMPLE_TAG;
    host(3'h6);
    exp_tx({40'h0, host_tag, 8'h20, 5'h10, host_lun}, 3);
    end_sim();
  end
endmodule // tb
